// ---- logic/imp_consts.svh ----
// constants for the interrupt mask and priority controller
// assumes inclusion by bare name from logic/ and verif/ files
`ifndef IMP_CONSTS_SVH
`define IMP_CONSTS_SVH
`define IMP_NSRC 10
`define IMP_VEC_W 8
`define IMP_ADDR_W 24
`define IMP_VEC_NONE 8'h00
`define IMP_VEC_NMI 8'h07
`define IMP_VEC_ABRK 8'h11
`define IMP_VEC_CMIA 8'h44
`define IMP_VEC_CMIB 8'h45
`define IMP_VEC_OVF 8'h46
`define IMP_VEC_ERI 8'h50
`define IMP_VEC_RXI 8'h51
`define IMP_VEC_TXI 8'h52
`define IMP_VEC_TEI 8'h53
`define IMP_VEC_USBA 8'h6c
`define IMP_VEC_USBB 8'h6d
`define IMP_VEC_USBC 8'h6e
`define IMP_ADDR_SHIFT 2
`define IMP_LVL_B_BIT 2
`define IMP_LVL_C_SER_BIT 7
`define IMP_LVL_C_USB_BIT 0
`endif

// ---- logic/imp_pkg.sv ----
// types for the interrupt mask and priority controller
// assumes imp_consts.svh sits alongside
package imp_pkg;
  typedef enum logic {IMP_MODE0, IMP_MODE1} imp_mode_t;
  typedef enum logic [1:0] {IMP_IDLE, IMP_RESOLVE, IMP_PRESENT} imp_state_t;
endpackage : imp_pkg

// ---- logic/imp_sel_if.sv ----
// carries mask-qualified requests and the resolved pick
// assumes one clock domain, joined inside imp_ctrl
`timescale 1ns/100ps
interface imp_sel_if #(parameter int N = 10);
  logic [N-1:0] req;
  logic [N-1:0] lvl;
  logic found;
  logic [$clog2(N)-1:0] idx;
  modport ctrl (output req, output lvl, input found, input idx);
  modport sel (input req, input lvl, output found, output idx);
endinterface : imp_sel_if

// ---- logic/imp_prio_sel.sv ----
// fixed-order priority pick, level 1 first then index order
// assumes index 0 is the highest default priority
`timescale 1ns/100ps
module imp_prio_sel #(parameter int N = 10) (
  imp_sel_if.sel s
);
  logic [N-1:0] hi;
  assign hi = s.req & s.lvl;
  always_comb begin
    s.found = 1'b0;
    s.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hi[i]) begin
        s.found = 1'b1;
        s.idx = i[$clog2(N)-1:0];
      end
    end
    if (hi == '0) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (s.req[i]) begin
          s.found = 1'b1;
          s.idx = i[$clog2(N)-1:0];
        end
      end
    end
  end
endmodule : imp_prio_sel

// ---- logic/imp_ctrl.sv ----
// interrupt mask, level and default priority controller
// assumes sources hold requests until serviced; sync inputs
`timescale 1ns/100ps
`include "imp_consts.svh"

module imp_ctrl #(
  parameter int N = `IMP_NSRC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic standby,
  input wire logic irq_mode_sel_hi,
  input wire logic irq_mode_sel_lo,
  input wire logic cpu_mask_bit,
  input wire logic cpu_user_mask_bit,
  input wire logic level_reg_b_bit2,
  input wire logic level_reg_c_bit7,
  input wire logic level_reg_c_bit0,
  input wire logic nmi_irq,
  input wire logic addr_break_irq,
  input wire logic timer1_match_a_irq,
  input wire logic timer1_match_b_irq,
  input wire logic timer1_overflow_irq,
  input wire logic serial_rx_error_irq,
  input wire logic serial_rx_done_irq,
  input wire logic serial_tx_empty_irq,
  input wire logic serial_tx_end_irq,
  input wire logic usb_irq_a,
  input wire logic usb_irq_b,
  input wire logic usb_irq_c,
  input wire logic cpu_ack,
  output logic irq_req_q,
  output logic [`IMP_VEC_W-1:0] vec_num_q,
  output logic [`IMP_ADDR_W-1:0] vec_addr_q,
  output logic mode_q
);
  // ****************************************************
  // source mapping
  // ****************************************************
  localparam int IW = $clog2(N);
  logic [N-1:0] src_req;
  logic [N-1:0] src_lvl;
  logic [`IMP_VEC_W-1:0] vec_tab [N];
  logic [N-1:0] accept;
  imp_pkg::imp_mode_t mode;
  imp_pkg::imp_state_t state_q;
  logic nmi_q;
  logic abrk_q;

  assign src_req = {usb_irq_c, usb_irq_b, usb_irq_a,
    serial_tx_end_irq, serial_tx_empty_irq, serial_rx_done_irq,
    serial_rx_error_irq, timer1_overflow_irq, timer1_match_b_irq,
    timer1_match_a_irq};
  assign src_lvl = {{3{level_reg_c_bit0}}, {4{level_reg_c_bit7}},
    {3{level_reg_b_bit2}}};
  assign vec_tab[0] = `IMP_VEC_CMIA;
  assign vec_tab[1] = `IMP_VEC_CMIB;
  assign vec_tab[2] = `IMP_VEC_OVF;
  assign vec_tab[3] = `IMP_VEC_ERI;
  assign vec_tab[4] = `IMP_VEC_RXI;
  assign vec_tab[5] = `IMP_VEC_TXI;
  assign vec_tab[6] = `IMP_VEC_TEI;
  assign vec_tab[7] = `IMP_VEC_USBA;
  assign vec_tab[8] = `IMP_VEC_USBB;
  assign vec_tab[9] = `IMP_VEC_USBC;

  // ****************************************************
  // mode and mask
  // ****************************************************
  // two modes only
  assign mode = irq_mode_sel_lo ? imp_pkg::IMP_MODE1 : imp_pkg::IMP_MODE0;

  always_comb begin
    accept = '0;
    if (!cpu_mask_bit) begin
      accept = src_req;
    end else if (mode == imp_pkg::IMP_MODE1 && !cpu_user_mask_bit) begin
      accept = src_req & src_lvl;
    end
  end

  imp_sel_if #(.N(N)) sif ();
  assign sif.req = accept;
  assign sif.lvl = src_lvl;
  imp_prio_sel #(.N(N)) u_sel (
    .s(sif.sel)
  );

  // ****************************************************
  // presentation
  // ****************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= (mode == imp_pkg::IMP_MODE1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || standby) begin
      nmi_q <= 1'b0;
      abrk_q <= 1'b0;
    end else begin
      nmi_q <= nmi_irq;
      abrk_q <= addr_break_irq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || standby) begin
      state_q <= imp_pkg::IMP_IDLE;
      irq_req_q <= 1'b0;
      vec_num_q <= `IMP_VEC_NONE;
      vec_addr_q <= '0;
    end else begin
      case (state_q)
        imp_pkg::IMP_IDLE: begin
          irq_req_q <= 1'b0;
          if (nmi_irq || addr_break_irq || sif.found) begin
            state_q <= imp_pkg::IMP_RESOLVE;
          end
        end
        imp_pkg::IMP_RESOLVE: begin
          if (nmi_q) begin
            vec_num_q <= `IMP_VEC_NMI;
            vec_addr_q <= {{(`IMP_ADDR_W-`IMP_VEC_W-`IMP_ADDR_SHIFT){1'b0}},
              `IMP_VEC_NMI, 2'b00};
            irq_req_q <= 1'b1;
            state_q <= imp_pkg::IMP_PRESENT;
          end else if (abrk_q) begin
            vec_num_q <= `IMP_VEC_ABRK;
            vec_addr_q <= {{(`IMP_ADDR_W-`IMP_VEC_W-`IMP_ADDR_SHIFT){1'b0}},
              `IMP_VEC_ABRK, 2'b00};
            irq_req_q <= 1'b1;
            state_q <= imp_pkg::IMP_PRESENT;
          end else if (sif.found) begin
            vec_num_q <= vec_tab[sif.idx];
            vec_addr_q <= {{(`IMP_ADDR_W-`IMP_VEC_W-`IMP_ADDR_SHIFT){1'b0}},
              vec_tab[sif.idx], 2'b00};
            irq_req_q <= 1'b1;
            state_q <= imp_pkg::IMP_PRESENT;
          end else begin
            state_q <= imp_pkg::IMP_IDLE;
          end
        end
        imp_pkg::IMP_PRESENT: begin
          if (cpu_ack) begin
            irq_req_q <= 1'b0;
            state_q <= imp_pkg::IMP_IDLE;
          end
        end
        default: begin
          state_q <= imp_pkg::IMP_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  sequence s_present;
    irq_req_q && state_q == imp_pkg::IMP_PRESENT;
  endsequence

  property p_mode_sel;
    @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> mode_q == $past(irq_mode_sel_lo);
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("mode flag does not follow low select bit");

  property p_nmi_taken;
    @(posedge core_clk) disable iff (!rstn || standby)
      (state_q == imp_pkg::IMP_RESOLVE && nmi_q) |=>
        s_present ##0 vec_num_q == `IMP_VEC_NMI;
  endproperty
  a_nmi_taken: assert property (p_nmi_taken)
    else $error("nmi not presented under mask");

  property p_mask0;
    @(posedge core_clk) disable iff (!rstn)
      (cpu_mask_bit && !irq_mode_sel_lo) |-> accept == '0;
  endproperty
  a_mask0: assert property (p_mask0)
    else $error("mode zero mask let a request through");

  property p_mask1;
    @(posedge core_clk) disable iff (!rstn)
      (cpu_mask_bit && irq_mode_sel_lo) |->
        (accept & ~src_lvl) == '0;
  endproperty
  a_mask1: assert property (p_mask1)
    else $error("mode one mask let level zero through");

  property p_lvl_win;
    @(posedge core_clk) disable iff (!rstn)
      ((accept & src_lvl) != '0) |-> src_lvl[sif.idx];
  endproperty
  a_lvl_win: assert property (p_lvl_win)
    else $error("level zero picked over level one");

  property p_order;
    @(posedge core_clk) disable iff (!rstn)
      sif.found |-> ((accept & ((N'(1) << sif.idx) - N'(1))
        & (src_lvl[sif.idx] ? src_lvl : ~src_lvl)) == '0);
  endproperty
  a_order: assert property (p_order)
    else $error("default order not respected");

  property p_vec_legal;
    @(posedge core_clk) disable iff (!rstn)
      irq_req_q |-> !(vec_num_q inside {8'h47, [8'h48:8'h4f],
        [8'h54:8'h6b], 8'h6f});
  endproperty
  a_vec_legal: assert property (p_vec_legal)
    else $error("reserved vector produced");

  property p_addr;
    @(posedge core_clk) disable iff (!rstn)
      irq_req_q |-> vec_addr_q == {14'h0000, vec_num_q, 2'b00};
  endproperty
  a_addr: assert property (p_addr)
    else $error("vector address not four times number");

  property p_resolve_first;
    @(posedge core_clk) disable iff (!rstn || standby)
      $rose(irq_req_q) |-> $past(state_q) == imp_pkg::IMP_RESOLVE;
  endproperty
  a_resolve_first: assert property (p_resolve_first)
    else $error("request shown before resolution");
endmodule : imp_ctrl

// ---- verif/imp_cpu_model.sv ----
// processor core model: takes each presented vector after a delay
// assumes irq_req_q stands until the acknowledge edge
`timescale 1ns/100ps
module imp_cpu_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq_req_q,
  input wire logic [1:0] ack_dly,
  output logic cpu_ack
);
  logic [1:0] cnt_q;
  logic done_q;
  // ***************************
  // acknowledge pulse, one per vector
  // ***************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cpu_ack <= 1'b0;
      cnt_q <= 2'h0;
      done_q <= 1'b0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      cnt_q <= 2'h0;
      done_q <= 1'b1;
    end else if (!irq_req_q) begin
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == ack_dly) cpu_ack <= 1'b1;
      else cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule : imp_cpu_model

// ---- verif/tb_interrupt_mask_priority_ctrl.sv ----
// self-checking bench for the interrupt mask and priority controller
// assumes sources hold requests until their vector is taken
`timescale 1ns/100ps
`include "imp_consts.svh"
module tb_interrupt_mask_priority_ctrl;
  logic core_clk = 0, rstn = 0, standby = 0, sel_hi = 0, sel_lo = 0;
  logic mask = 0, umask = 0, lvl_b = 0, lvl_c7 = 0, lvl_c0 = 0;
  logic [11:0] src = 12'h000;
  logic [1:0] ack_dly = 2'h0;
  logic cpu_ack, irq_req_q, mode_q;
  logic [7:0] vec_num_q;
  logic [23:0] vec_addr_q;
  int n_errors = 0;
  int checks_done = 0;
  // source order: nmi, break, timer a/b/ovf, serial x4, usb a/b/c
  localparam logic [7:0] VT [12] = '{`IMP_VEC_NMI, `IMP_VEC_ABRK,
    `IMP_VEC_CMIA, `IMP_VEC_CMIB, `IMP_VEC_OVF, `IMP_VEC_ERI,
    `IMP_VEC_RXI, `IMP_VEC_TXI, `IMP_VEC_TEI, `IMP_VEC_USBA,
    `IMP_VEC_USBB, `IMP_VEC_USBC};
  always #5 core_clk = ~core_clk;
  imp_ctrl i_imp_ctrl (.core_clk(core_clk), .rstn(rstn),
    .standby(standby), .irq_mode_sel_hi(sel_hi), .irq_mode_sel_lo(sel_lo),
    .cpu_mask_bit(mask), .cpu_user_mask_bit(umask),
    .level_reg_b_bit2(lvl_b), .level_reg_c_bit7(lvl_c7),
    .level_reg_c_bit0(lvl_c0), .nmi_irq(src[0]), .addr_break_irq(src[1]),
    .timer1_match_a_irq(src[2]), .timer1_match_b_irq(src[3]),
    .timer1_overflow_irq(src[4]), .serial_rx_error_irq(src[5]),
    .serial_rx_done_irq(src[6]), .serial_tx_empty_irq(src[7]),
    .serial_tx_end_irq(src[8]), .usb_irq_a(src[9]), .usb_irq_b(src[10]),
    .usb_irq_c(src[11]), .cpu_ack(cpu_ack), .irq_req_q(irq_req_q),
    .vec_num_q(vec_num_q), .vec_addr_q(vec_addr_q), .mode_q(mode_q));
  imp_cpu_model i_imp_cpu_model (.core_clk(core_clk), .rstn(rstn),
    .irq_req_q(irq_req_q), .ack_dly(ack_dly), .cpu_ack(cpu_ack));
  // ***************************
  // shared tasks
  // ***************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // waits for the acknowledge edge, then retires the source
  task automatic serve(input int idx);
    int k;
    for (k = 0; k < 30; k++) begin
      @(posedge core_clk);
      if (cpu_ack === 1'b1) break;
    end
    if (k == 30) begin
      n_errors++;
      results();
    end
    chk(vec_num_q, VT[idx]);
    chk(vec_addr_q, {22'h0, VT[idx], 2'h0});
    #1 src[idx] = 1'b0;
  endtask : serve
  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      step(1);
      if (irq_req_q !== 1'b0) hits++;
    end
    chk(hits, 0);
  endtask : quiet
  // ***************************
  // scenarios
  // ***************************
  task automatic t_reset();
    chk({irq_req_q, mode_q}, 0);
    chk(vec_num_q, `IMP_VEC_NONE);
    chk(vec_addr_q, 0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_order();
    ack_dly = 2'h2;
    src = 12'hfff;
    for (int i = 0; i < 12; i++) serve(i);
    quiet(5);
    $display("t_order done");
  endtask : t_order
  task automatic t_level();
    ack_dly = 2'h0;
    lvl_c7 = 1'b1;
    src = 12'h824;
    serve(5);
    serve(2);
    serve(11);
    lvl_c7 = 1'b0;
    $display("t_level done");
  endtask : t_level
  task automatic t_mask0();
    ack_dly = 2'h1;
    mask = 1'b1;
    lvl_c0 = 1'b1;
    src = 12'h204;
    quiet(8);
    src[0] = 1'b1;
    serve(0);
    mask = 1'b0;
    serve(9);
    serve(2);
    $display("t_mask0 done");
  endtask : t_mask0
  task automatic t_mask1();
    ack_dly = 2'h3;
    {sel_hi, sel_lo, mask, umask} = 4'hf;
    step(2);
    chk(mode_q, 1);
    src = 12'h204;
    quiet(8);
    umask = 1'b0;
    serve(9);
    quiet(8);
    mask = 1'b0;
    serve(2);
    {sel_hi, sel_lo, lvl_c0} = 3'h0;
    step(2);
    chk(mode_q, 0);
    $display("t_mask1 done");
  endtask : t_mask1
  task automatic t_standby();
    standby = 1'b1;
    src[1] = 1'b1;
    quiet(8);
    standby = 1'b0;
    serve(1);
    $display("t_standby done");
  endtask : t_standby
  initial begin
    step(16);
    rstn = 1'b1;
    step(1);
    t_reset();
    t_order();
    t_level();
    t_mask0();
    t_mask1();
    t_standby();
    results();
  end
endmodule : tb_interrupt_mask_priority_ctrl
